// ### src/dsc_fault_sub.sv
// one fifo path: passes the symbol, or the programmed fault symbol while the fifo flags an error
`timescale 1ns/1ps
module dsc_fault_sub
(
	input logic clk_i,
	input logic rst_n_i,
	input dsc_pkg::dsc_sym_t sym_i,
	input logic fifo_err_i,
	input dsc_pkg::dsc_sym_t fault_code_i,
	output dsc_pkg::dsc_sym_t sym_o,
	output logic fault_o
);
	import dsc_pkg::*;

	// one register stage; the code is read live so a rewrite takes effect on the next error cycle
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sym_o <= '0;
			fault_o <= 1'b0;
		end
		else
		begin
			sym_o <= fifo_err_i ? fault_code_i : sym_i;
			fault_o <= fifo_err_i;
		end
	end
endmodule

// ### src/dsc_params.svh
// offsets, field positions and reset values of the descrambler and fault symbol register group
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

// register offsets on the management port
`define DSC_UNSCR_CTRL_OFF 16'h8019
`define DSC_SEED_HI_OFF 16'h801C
`define DSC_SEED_LO_OFF 16'h801D
`define DSC_POLY_HI_OFF 16'h801E
`define DSC_POLY_LO_OFF 16'h801F
`define DSC_CHECK_CTRL_OFF 16'h8021
`define DSC_SLOW_TX_CODE_OFF 16'h8026
`define DSC_SLOW_RX_CODE_OFF 16'h8027
`define DSC_FAST_RX_CODE_OFF 16'h8028
`define DSC_FAST_TX_CODE_OFF 16'h8029
`define DSC_STARTUP_STAT_OFF 16'h9020
`define DSC_PARTNER_REQ_OFF 16'h9098

// reset values
`define DSC_UNSCR_CTRL_RST 16'hFC00
`define DSC_SEED_HI_RST 16'h0000
`define DSC_SEED_LO_RST 16'h01FC
`define DSC_POLY_HI_RST 16'h0000
`define DSC_POLY_LO_RST 16'h00C0
`define DSC_CHECK_CTRL_RST 16'h000A
`define DSC_FAULT_CODE_RST 10'h2FE

// field positions
`define DSC_WIDE_ON_BIT 1
`define DSC_NARROW_ON_BIT 0
`define DSC_PLL_CHECK_OFF_BIT 6
`define DSC_LOS_CHECK_OFF_BIT 5
`define DSC_CLK_HOLD_BIT 3
`define DSC_STARTUP_BIT 0
`define DSC_PRESET_BIT 13
`define DSC_INIT_BIT 12

`endif

// ### src/dsc_pkg.sv
// types shared by the descrambler and fault symbol register group
package dsc_pkg;
	typedef logic [15:0] dsc_addr_t;
	typedef logic [15:0] dsc_word_t;
	typedef logic [9:0] dsc_sym_t;
	// order of the four fifo paths inside the substitution array
	typedef enum logic [1:0]
	{
		DSC_SLOW_TX = 2'h0,
		DSC_SLOW_RX = 2'h1,
		DSC_FAST_RX = 2'h3,
		DSC_FAST_TX = 2'h2
	} dsc_path_e;
endpackage

// ### src/dsc_regs_top.sv
// descrambler setup, link check control and fifo fault symbol register group
`timescale 1ns/1ps
`include "dsc_params.svh"
module dsc_regs_top
(
	input logic clk_i,
	input logic rst_n_i,
	input logic mgmt_req_i,
	input logic mgmt_we_i,
	input dsc_pkg::dsc_addr_t mgmt_addr_i,
	input dsc_pkg::dsc_word_t mgmt_wdata_i,
	output dsc_pkg::dsc_word_t mgmt_rdata_o,
	output logic mgmt_ack_o,
	output logic [31:0] unscramble_start_value_o,
	output logic [31:0] unscramble_feedback_taps_o,
	output logic start_value_load_o,
	output logic wide_unscramble_on_o,
	output logic narrow_unscramble_on_o,
	output logic fast_pll_lock_check_off_o,
	output logic fast_signal_absent_check_off_o,
	input logic clock_output_pin_recovered_i,
	input logic fast_signal_absent_i,
	output logic clock_output_pin_hold_o,
	input logic startup_in_progress_i,
	input logic partner_preset_request_i,
	input logic partner_init_request_i,
	input dsc_pkg::dsc_sym_t slow_tx_sym_i,
	input logic slow_tx_fifo_err_i,
	output dsc_pkg::dsc_sym_t slow_tx_sym_o,
	output logic slow_tx_fault_o,
	input dsc_pkg::dsc_sym_t slow_rx_sym_i,
	input logic slow_rx_fifo_err_i,
	output dsc_pkg::dsc_sym_t slow_rx_sym_o,
	output logic slow_rx_fault_o,
	input dsc_pkg::dsc_sym_t fast_rx_sym_i,
	input logic fast_rx_fifo_err_i,
	output dsc_pkg::dsc_sym_t fast_rx_sym_o,
	output logic fast_rx_fault_o,
	input dsc_pkg::dsc_sym_t fast_tx_sym_i,
	input logic fast_tx_fifo_err_i,
	output dsc_pkg::dsc_sym_t fast_tx_sym_o,
	output logic fast_tx_fault_o
);
	import dsc_pkg::*;

	localparam int NPATH = 4;
	localparam dsc_addr_t CODE_OFF [NPATH] = '{`DSC_SLOW_TX_CODE_OFF, `DSC_SLOW_RX_CODE_OFF,
		`DSC_FAST_RX_CODE_OFF, `DSC_FAST_TX_CODE_OFF};

	// stored register words
	dsc_word_t seed_hi_r;
	dsc_word_t seed_lo_r;
	dsc_word_t poly_hi_r;
	dsc_word_t poly_lo_r;
	dsc_word_t unscr_ctrl_r;
	dsc_word_t check_ctrl_r;
	dsc_sym_t code_r [NPATH];
	dsc_word_t rdata_nxt;
	logic wr_en;

	// synchronised status levels, read only after the second flip-flop
	logic [3:0] sync_s;
	logic los_s;
	logic startup_s;
	logic preset_s;
	logic init_s;

	// per-path views of the four fifo interfaces
	dsc_sym_t path_sym [NPATH];
	logic path_err [NPATH];
	dsc_sym_t path_out [NPATH];
	logic path_fault [NPATH];

	// address match, shared by the write decode of every register
	function automatic logic hit(input dsc_addr_t addr, input dsc_addr_t off);
		hit = (addr == off);
	endfunction

	assign wr_en = mgmt_req_i & mgmt_we_i;

	// levels from the analog front end and the training logic arrive from other clocks
	dsc_sync2 #(.WIDTH(4)) u_sync
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i({fast_signal_absent_i, startup_in_progress_i, partner_preset_request_i, partner_init_request_i}),
		.sync_o(sync_s)
	);
	assign los_s = sync_s[3];
	assign startup_s = sync_s[2];
	assign preset_s = sync_s[1];
	assign init_s = sync_s[0];

	// seed halves; bit 0 of the low half is never stored
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			seed_hi_r <= `DSC_SEED_HI_RST;
			seed_lo_r <= `DSC_SEED_LO_RST;
		end
		else if (wr_en)
		begin
			if (hit(mgmt_addr_i, `DSC_SEED_HI_OFF))
				seed_hi_r <= mgmt_wdata_i;
			if (hit(mgmt_addr_i, `DSC_SEED_LO_OFF))
				seed_lo_r <= {mgmt_wdata_i[15:1], 1'b0};
		end
	end

	// one-cycle strobe after either seed half is written, so the descrambler can reload
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			start_value_load_o <= 1'b0;
		else
			start_value_load_o <= wr_en & (hit(mgmt_addr_i, `DSC_SEED_HI_OFF) | hit(mgmt_addr_i, `DSC_SEED_LO_OFF));
	end

	// polynomial halves; bit 0 of the low half is never stored
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			poly_hi_r <= `DSC_POLY_HI_RST;
			poly_lo_r <= `DSC_POLY_LO_RST;
		end
		else if (wr_en)
		begin
			if (hit(mgmt_addr_i, `DSC_POLY_HI_OFF))
				poly_hi_r <= mgmt_wdata_i;
			if (hit(mgmt_addr_i, `DSC_POLY_LO_OFF))
				poly_lo_r <= {mgmt_wdata_i[15:1], 1'b0};
		end
	end

	// descrambler enables; reserved upper bits are kept as written
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			unscr_ctrl_r <= `DSC_UNSCR_CTRL_RST;
		else if (wr_en && hit(mgmt_addr_i, `DSC_UNSCR_CTRL_OFF))
			unscr_ctrl_r <= mgmt_wdata_i;
	end

	// check disables and clock hold; the whole word is stored so reserved fields read back
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			check_ctrl_r <= `DSC_CHECK_CTRL_RST;
		else if (wr_en && hit(mgmt_addr_i, `DSC_CHECK_CTRL_OFF))
			check_ctrl_r <= mgmt_wdata_i;
	end

	// fault symbols, ten bits each; upper write bits are dropped
	genvar g;
	generate
		for (g = 0; g < NPATH; g++)
		begin : g_code
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
					code_r[g] <= `DSC_FAULT_CODE_RST;
				else if (wr_en && hit(mgmt_addr_i, CODE_OFF[g]))
					code_r[g] <= mgmt_wdata_i[9:0];
			end
		end
	endgenerate

	// configuration seen by the datapath, straight from the stored words
	assign unscramble_start_value_o = {seed_hi_r, seed_lo_r};
	assign unscramble_feedback_taps_o = {poly_hi_r, poly_lo_r};
	assign wide_unscramble_on_o = unscr_ctrl_r[`DSC_WIDE_ON_BIT];
	assign narrow_unscramble_on_o = unscr_ctrl_r[`DSC_NARROW_ON_BIT];
	assign fast_pll_lock_check_off_o = check_ctrl_r[`DSC_PLL_CHECK_OFF_BIT];
	assign fast_signal_absent_check_off_o = check_ctrl_r[`DSC_LOS_CHECK_OFF_BIT];

	// hold only applies when the pin carries the recovered byte clock
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			clock_output_pin_hold_o <= 1'b0;
		else
			clock_output_pin_hold_o <= check_ctrl_r[`DSC_CLK_HOLD_BIT] & clock_output_pin_recovered_i & los_s;
	end

	// fifo paths gathered into arrays indexed by the path enum; each of the four paths has its own substitution stage
	assign path_sym[DSC_SLOW_TX] = slow_tx_sym_i;
	assign path_sym[DSC_SLOW_RX] = slow_rx_sym_i;
	assign path_sym[DSC_FAST_RX] = fast_rx_sym_i;
	assign path_sym[DSC_FAST_TX] = fast_tx_sym_i;
	assign path_err[DSC_SLOW_TX] = slow_tx_fifo_err_i;
	assign path_err[DSC_SLOW_RX] = slow_rx_fifo_err_i;
	assign path_err[DSC_FAST_RX] = fast_rx_fifo_err_i;
	assign path_err[DSC_FAST_TX] = fast_tx_fifo_err_i;

	// code_r index follows CODE_OFF order, path index follows the enum
	dsc_fault_sub u_slow_tx
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sym_i(path_sym[DSC_SLOW_TX]),
		.fifo_err_i(path_err[DSC_SLOW_TX]),
		.fault_code_i(code_r[0]),
		.sym_o(path_out[DSC_SLOW_TX]),
		.fault_o(path_fault[DSC_SLOW_TX])
	);
	dsc_fault_sub u_slow_rx
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sym_i(path_sym[DSC_SLOW_RX]),
		.fifo_err_i(path_err[DSC_SLOW_RX]),
		.fault_code_i(code_r[1]),
		.sym_o(path_out[DSC_SLOW_RX]),
		.fault_o(path_fault[DSC_SLOW_RX])
	);
	dsc_fault_sub u_fast_rx
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sym_i(path_sym[DSC_FAST_RX]),
		.fifo_err_i(path_err[DSC_FAST_RX]),
		.fault_code_i(code_r[2]),
		.sym_o(path_out[DSC_FAST_RX]),
		.fault_o(path_fault[DSC_FAST_RX])
	);
	dsc_fault_sub u_fast_tx
	(
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.sym_i(path_sym[DSC_FAST_TX]),
		.fifo_err_i(path_err[DSC_FAST_TX]),
		.fault_code_i(code_r[3]),
		.sym_o(path_out[DSC_FAST_TX]),
		.fault_o(path_fault[DSC_FAST_TX])
	);

	assign slow_tx_sym_o = path_out[DSC_SLOW_TX];
	assign slow_rx_sym_o = path_out[DSC_SLOW_RX];
	assign fast_rx_sym_o = path_out[DSC_FAST_RX];
	assign fast_tx_sym_o = path_out[DSC_FAST_TX];
	assign slow_tx_fault_o = path_fault[DSC_SLOW_TX];
	assign slow_rx_fault_o = path_fault[DSC_SLOW_RX];
	assign fast_rx_fault_o = path_fault[DSC_FAST_RX];
	assign fast_tx_fault_o = path_fault[DSC_FAST_TX];

	// read decode; unmapped offsets read zero, reserved bits of the two control words read back as written
	always_comb
	begin
		case (mgmt_addr_i)
			`DSC_UNSCR_CTRL_OFF: rdata_nxt = unscr_ctrl_r;
			`DSC_SEED_HI_OFF: rdata_nxt = seed_hi_r;
			`DSC_SEED_LO_OFF: rdata_nxt = seed_lo_r;
			`DSC_POLY_HI_OFF: rdata_nxt = poly_hi_r;
			`DSC_POLY_LO_OFF: rdata_nxt = poly_lo_r;
			`DSC_CHECK_CTRL_OFF: rdata_nxt = check_ctrl_r;
			`DSC_SLOW_TX_CODE_OFF: rdata_nxt = {6'h00, code_r[0]};
			`DSC_SLOW_RX_CODE_OFF: rdata_nxt = {6'h00, code_r[1]};
			`DSC_FAST_RX_CODE_OFF: rdata_nxt = {6'h00, code_r[2]};
			`DSC_FAST_TX_CODE_OFF: rdata_nxt = {6'h00, code_r[3]};
			`DSC_STARTUP_STAT_OFF: rdata_nxt = 16'(startup_s) << `DSC_STARTUP_BIT;
			`DSC_PARTNER_REQ_OFF:
			begin
				rdata_nxt = 16'(preset_s) << `DSC_PRESET_BIT;
				rdata_nxt = rdata_nxt | (16'(init_s) << `DSC_INIT_BIT);
			end
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// every request is answered one cycle later, writes included; read data holds until the next read
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			mgmt_ack_o <= 1'b0;
			mgmt_rdata_o <= 16'h0000;
		end
		else
		begin
			mgmt_ack_o <= mgmt_req_i;
			if (mgmt_req_i && !mgmt_we_i)
				mgmt_rdata_o <= rdata_nxt;
		end
	end
endmodule

// ### src/dsc_sync2.sv
// two flip-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ps
module dsc_sync2
#(
	parameter int WIDTH = 4
)
(
	input logic clk_i,
	input logic rst_n_i,
	input logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_r;

	// each bit crosses on its own; the bits are unrelated levels, so no coherence is needed
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++)
		begin : g_bit
			always_ff @(posedge clk_i or negedge rst_n_i)
			begin
				if (!rst_n_i)
				begin
					meta_r[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end
				else
				begin
					meta_r[g] <= async_i[g];
					sync_o[g] <= meta_r[g];
				end
			end
		end
	endgenerate
endmodule

// ### tb/dsc_regs_checker.sv
// concurrent checks on the register group ports
`timescale 1ns/1ps
module dsc_regs_checker
(
	input logic clk_i,
	input logic rst_n_i,
	input logic mgmt_req_i,
	input logic mgmt_we_i,
	input logic [15:0] mgmt_addr_i,
	input logic [15:0] mgmt_wdata_i,
	input logic [15:0] mgmt_rdata_o,
	input logic mgmt_ack_o,
	input logic [31:0] unscramble_start_value_o,
	input logic [31:0] unscramble_feedback_taps_o,
	input logic start_value_load_o,
	input logic clock_output_pin_recovered_i,
	input logic clock_output_pin_hold_o,
	input logic fast_pll_lock_check_off_o,
	input logic fast_signal_absent_check_off_o,
	input logic [9:0] slow_rx_sym_i,
	input logic slow_rx_fifo_err_i,
	input logic [9:0] slow_rx_sym_o,
	input logic slow_tx_fifo_err_i,
	input logic slow_tx_fault_o
);
	logic wr;
	logic rd;
	// write and read strobes as taken on the management port
	assign wr = mgmt_req_i & mgmt_we_i;
	assign rd = mgmt_req_i & ~mgmt_we_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_ack_next: assert property (mgmt_req_i |=> mgmt_ack_o)
		else $error("ack missing after request");
	a_seed_low_half: assert property (wr && mgmt_addr_i == 16'h801D |=>
		unscramble_start_value_o[15:0] == ($past(mgmt_wdata_i) & 16'hFFFE)) else $error("seed low half wrong");
	a_poly_low_half: assert property (wr && mgmt_addr_i == 16'h801F |=>
		unscramble_feedback_taps_o[15:0] == ($past(mgmt_wdata_i) & 16'hFFFE)) else $error("taps low half wrong");
	a_pll_check_off: assert property (wr && mgmt_addr_i == 16'h8021 |=>
		fast_pll_lock_check_off_o == $past(mgmt_wdata_i[6])) else $error("pll check control wrong");
	a_los_check_off: assert property (wr && mgmt_addr_i == 16'h8021 |=>
		fast_signal_absent_check_off_o == $past(mgmt_wdata_i[5])) else $error("signal check control wrong");
	a_code_upper_zero: assert property (rd && mgmt_addr_i == 16'h8027 |=> mgmt_rdata_o[15:10] == 6'h00)
		else $error("fault code upper bits set");
	a_path_passes: assert property (!slow_rx_fifo_err_i |=> slow_rx_sym_o == $past(slow_rx_sym_i))
		else $error("symbol not passed");
	a_fault_flagged: assert property (slow_tx_fifo_err_i |=> slow_tx_fault_o)
		else $error("fault flag missing");
	a_load_strobe: assert property (wr && (mgmt_addr_i == 16'h801C || mgmt_addr_i == 16'h801D) |=>
		start_value_load_o) else $error("seed reload strobe missing");
	a_hold_needs_pin: assert property (!clock_output_pin_recovered_i |=> !clock_output_pin_hold_o)
		else $error("clock held while pin carries another clock");
	// main scenarios reached
	c_ctrl_write: cover property (wr && mgmt_addr_i == 16'h8021);
	c_fifo_fault: cover property (slow_tx_fifo_err_i);
	c_partner_read: cover property (rd && mgmt_addr_i == 16'h9098);
	c_clock_hold: cover property (clock_output_pin_hold_o);
endmodule

// ### tb/testbench.sv
// register access and fault path bench for the register group
`timescale 1ns/1ps
module testbench;
	import dsc_pkg::*;
	logic clk_i;
	logic rst_n_i;
	logic req, we, ack, load, wide_on, narrow_on, pll_off, los_off, recov, los, hold, startup, preset, init_req;
	dsc_addr_t addr;
	dsc_word_t wdata, rdata;
	logic [31:0] seed, taps;
	dsc_sym_t sym_in [4];
	dsc_sym_t sym_out [4];
	logic err [4];
	logic flt [4];
	int error_cnt = 0;
	int n_compared = 0;
	// paths indexed in code register order 0x8026..0x8029
	dsc_regs_top i_dut
	(
		.clk_i(clk_i), .rst_n_i(rst_n_i), .mgmt_req_i(req), .mgmt_we_i(we), .mgmt_addr_i(addr),
		.mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .mgmt_ack_o(ack), .unscramble_start_value_o(seed),
		.unscramble_feedback_taps_o(taps), .start_value_load_o(load), .wide_unscramble_on_o(wide_on),
		.narrow_unscramble_on_o(narrow_on), .fast_pll_lock_check_off_o(pll_off),
		.fast_signal_absent_check_off_o(los_off), .clock_output_pin_recovered_i(recov),
		.fast_signal_absent_i(los), .clock_output_pin_hold_o(hold), .startup_in_progress_i(startup),
		.partner_preset_request_i(preset), .partner_init_request_i(init_req),
		.slow_tx_sym_i(sym_in[0]), .slow_tx_fifo_err_i(err[0]), .slow_tx_sym_o(sym_out[0]), .slow_tx_fault_o(flt[0]),
		.slow_rx_sym_i(sym_in[1]), .slow_rx_fifo_err_i(err[1]), .slow_rx_sym_o(sym_out[1]), .slow_rx_fault_o(flt[1]),
		.fast_rx_sym_i(sym_in[2]), .fast_rx_fifo_err_i(err[2]), .fast_rx_sym_o(sym_out[2]), .fast_rx_fault_o(flt[2]),
		.fast_tx_sym_i(sym_in[3]), .fast_tx_fifo_err_i(err[3]), .fast_tx_sym_o(sym_out[3]), .fast_tx_fault_o(flt[3])
	);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one request pulse; the ack is looked at in the cycle it stands
	task acc(input logic w, input dsc_addr_t a, input dsc_word_t d);
		@(posedge clk_i);
		#1;
		req = 1'b1;
		we = w;
		addr = a;
		wdata = d;
		@(posedge clk_i);
		#1;
		req = 1'b0;
		chk(ack, 1'b1);
	endtask
	task rd(input dsc_addr_t a, input dsc_word_t e);
		acc(1'b0, a, 16'h0000);
		chk(rdata, e);
	endtask
	task settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task give_verdict;
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// free running clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// a hung handshake must still end the run
	initial
	begin
		repeat (3000) @(posedge clk_i);
		error_cnt++;
		give_verdict;
	end
	initial
	begin
		{rst_n_i, req, we, recov, los, startup, preset, init_req} = 8'h00;
		addr = 16'h0000;
		wdata = 16'h0000;
		for (int i = 0; i < 4; i++)
		begin
			sym_in[i] = 10'(10'h155 + i);
			err[i] = 1'b0;
		end
		settle(20);
		rst_n_i = 1'b1;
		chk(seed, 32'h000001FC);
		chk(taps, 32'h000000C0);
		chk({wide_on, narrow_on}, 2'b00);
		chk(load, 1'b0);
		rd(16'h8019, 16'hFC00);
		rd(16'h801C, 16'h0000);
		rd(16'h801D, 16'h01FC);
		rd(16'h801E, 16'h0000);
		rd(16'h801F, 16'h00C0);
		rd(16'h8021, 16'h000A);
		rd(16'h8030, 16'h0000);
		// seed and taps halves, low bit forced clear
		acc(1'b1, 16'h801C, 16'h1234);
		chk(load, 1'b1);
		acc(1'b1, 16'h801D, 16'hFFFF);
		chk(seed, 32'h1234FFFE);
		rd(16'h801D, 16'hFFFE);
		acc(1'b1, 16'h801E, 16'hA5A5);
		chk(load, 1'b0);
		acc(1'b1, 16'h801F, 16'h0001);
		chk(taps, 32'hA5A50000);
		acc(1'b1, 16'h8019, 16'hFC03);
		chk({wide_on, narrow_on}, 2'b11);
		acc(1'b1, 16'h804A - 16'h0029, 16'h004A);
		chk({pll_off, los_off}, 2'b10);
		acc(1'b1, 16'h8021, 16'h002A);
		chk({pll_off, los_off}, 2'b01);
		// clock hold follows signal loss only while enabled
		recov = 1'b1;
		los = 1'b1;
		settle(5);
		chk(hold, 1'b1);
		acc(1'b1, 16'h8021, 16'h0022);
		settle(2);
		chk(hold, 1'b0);
		acc(1'b1, 16'h8021, 16'h000A);
		settle(2);
		chk(hold, 1'b1);
		recov = 1'b0;
		settle(2);
		chk(hold, 1'b0);
		recov = 1'b1;
		los = 1'b0;
		settle(4);
		chk(hold, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			rd(16'(16'h8026 + i), 16'h02FE);
			acc(1'b1, 16'(16'h8026 + i), 16'(16'hFC40 + i));
			rd(16'(16'h8026 + i), 16'(16'h0040 + i));
			err[i] = 1'b1;
			settle(1);
			chk({flt[i], sym_out[i]}, {1'b1, 10'(10'h040 + i)});
			err[i] = 1'b0;
			settle(1);
			chk({flt[i], sym_out[i]}, {1'b0, sym_in[i]});
		end
		// read-only status follows the synchronised inputs
		acc(1'b1, 16'h9020, 16'hFFFF);
		rd(16'h9020, 16'h0000);
		startup = 1'b1;
		preset = 1'b1;
		settle(3);
		rd(16'h9020, 16'h0001);
		rd(16'h9098, 16'h2000);
		preset = 1'b0;
		init_req = 1'b1;
		startup = 1'b0;
		settle(3);
		rd(16'h9098, 16'h1000);
		rd(16'h9020, 16'h0000);
		give_verdict;
	end
endmodule
bind dsc_regs_top dsc_regs_checker i_chk (.*);
